// ==== common/pmt_consts.vh ====
// constants for the 8-bit period match timer
// included by the core module; definitions only
`ifndef PMT_CONSTS_VH
`define PMT_CONSTS_VH

// ****************************************
// register word offsets (byte address / 4)
// ****************************************
`define PMT_ADDR_CTRL 2'h0
`define PMT_ADDR_COUNT 2'h1
`define PMT_ADDR_PERIOD 2'h2
`define PMT_ADDR_FLAG 2'h3

// ****************************************
// control register fields
// ****************************************
`define PMT_CTRL_POST_HI 6
`define PMT_CTRL_POST_LO 3
`define PMT_CTRL_RUN 2
`define PMT_CTRL_PRE_HI 1
`define PMT_CTRL_PRE_LO 0
`define PMT_CTRL_MASK 8'h7f

// ****************************************
// reset values and codes
// ****************************************
`define PMT_CTRL_RST 8'h00
`define PMT_COUNT_RST 8'h00
`define PMT_PERIOD_RST 8'hff
`define PMT_FLAG_BIT 0
`define PMT_PRE_DIV1 2'h0
`define PMT_PRE_DIV4 2'h1
`define PMT_PRE_LAST1 4'h0
`define PMT_PRE_LAST4 4'h3
`define PMT_PRE_LAST16 4'hf
`define PMT_INSTR_DIV_LAST 2'h3

`endif

// ==== core/pmt_timer.v ====
// 8-bit period match timer with prescaler, postscaler and match flag
// assumes one system clock (oscillator), avalon-mm slave, word addresses
//
// Behaviour
// - input clock is oscillator divided by four, feeding the prescaler
// - prescaler divides by 1 for 00, 4 for 01, 16 for 1x
// - each prescaler pulse advances the count while running
// - count rises from zero, compared constantly against the period
// - on match the next increment loads zero instead
// - each match advances the postscaler counter
// - postscaler divides matches by select value plus one
// - each postscaler output sets the period match flag
// - count and period registers fully readable and writable anytime
// - reset clears count and sets period to all ones
// - run bit 2 starts and stops counting
// - postscale select in bits 6..3, prescale select in bits 1..0
// - scalers clear on count write, control write, reset
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`include "pmt_consts.vh"

module pmt_timer
(
	// clock and reset
	input wire CLK_SYS,
	input wire RST_N,
	// avalon-mm slave
	input wire [1:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	output reg [31:0] AVS_READDATA,
	output reg AVS_WAITREQUEST,
	output reg [1:0] AVS_RESPONSE,
	// timer state
	output reg PERIOD_MATCH_FLAG,
	output reg POSTSCALE_PULSE
);

	// ****************************************
	// registers
	// ****************************************
	reg [7:0] timer_control_reg;
	reg [7:0] count_register;
	reg [7:0] period_register;
	reg [1:0] instr_div;
	reg [3:0] pre_cnt;
	reg [3:0] post_cnt;
	reg done;

	wire [1:0] prescale_select;
	wire [3:0] postscale_select;
	wire timer_run_bit;
	wire instr_tick;
	reg [3:0] pre_last;
	wire pre_tick;
	wire match;
	wire post_out;
	wire access;
	wire wr_ok;
	wire lane0;
	wire wr_ctrl;
	wire wr_count;
	wire wr_period;
	wire wr_flag;
	wire scaler_clr;

	assign prescale_select =
		timer_control_reg[`PMT_CTRL_PRE_HI:`PMT_CTRL_PRE_LO];
	assign postscale_select =
		timer_control_reg[`PMT_CTRL_POST_HI:`PMT_CTRL_POST_LO];
	assign timer_run_bit = timer_control_reg[`PMT_CTRL_RUN];

	// ****************************************
	// bus decode
	// ****************************************
	// one wait state: request taken on the edge where waitrequest is high, answered with waitrequest low the next cycle
	assign access = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST & ~done;
	assign lane0 = AVS_BYTEENABLE[0];
	assign wr_ok = access & AVS_WRITE & lane0;
	assign wr_ctrl = wr_ok & (AVS_ADDRESS == `PMT_ADDR_CTRL);
	assign wr_count = wr_ok & (AVS_ADDRESS == `PMT_ADDR_COUNT);
	assign wr_period = wr_ok & (AVS_ADDRESS == `PMT_ADDR_PERIOD);
	assign wr_flag = wr_ok & (AVS_ADDRESS == `PMT_ADDR_FLAG);
	assign scaler_clr = wr_ctrl | wr_count;

	// ****************************************
	// clock chain
	// ****************************************
	// instruction rate is one quarter of the system clock
	assign instr_tick = (instr_div == `PMT_INSTR_DIV_LAST);

	always @*
	begin
		if (prescale_select == `PMT_PRE_DIV1)
			pre_last = `PMT_PRE_LAST1;
		else if (prescale_select == `PMT_PRE_DIV4)
			pre_last = `PMT_PRE_LAST4;
		else
			pre_last = `PMT_PRE_LAST16;
	end

	// a count or control write wins over a step, so no pulse either
	assign pre_tick = timer_run_bit & instr_tick & ~scaler_clr &
		(pre_cnt >= pre_last);
	assign match = (count_register == period_register);
	assign post_out = pre_tick & match &
		(post_cnt >= postscale_select);

	always @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
			instr_div <= 2'h0;
		else
			instr_div <= instr_div + 2'h1;
	end

	// ****************************************
	// prescaler, count and postscaler
	// ****************************************
	always @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pre_cnt <= 4'h0;
			post_cnt <= 4'h0;
			count_register <= `PMT_COUNT_RST;
		end
		else if (wr_count)
		begin
			// a write replaces the count; no increment that cycle
			count_register <= AVS_WRITEDATA[7:0];
			pre_cnt <= 4'h0;
			post_cnt <= 4'h0;
		end
		else if (wr_ctrl)
		begin
			// count kept as is on a control write
			pre_cnt <= 4'h0;
			post_cnt <= 4'h0;
		end
		else if (timer_run_bit && instr_tick)
		begin
			if (pre_tick)
			begin
				pre_cnt <= 4'h0;
				if (match)
				begin
					count_register <= `PMT_COUNT_RST;
					if (post_out)
						post_cnt <= 4'h0;
					else
						post_cnt <= post_cnt + 4'h1;
				end
				else
					count_register <= count_register + 8'h01;
			end
			else
				pre_cnt <= pre_cnt + 4'h1;
		end
	end

	// ****************************************
	// software registers and flag
	// ****************************************
	always @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			timer_control_reg <= `PMT_CTRL_RST;
			period_register <= `PMT_PERIOD_RST;
			PERIOD_MATCH_FLAG <= 1'b0;
			POSTSCALE_PULSE <= 1'b0;
		end
		else
		begin
			POSTSCALE_PULSE <= post_out;
			if (wr_ctrl)
				timer_control_reg <=
					AVS_WRITEDATA[7:0] & `PMT_CTRL_MASK;
			if (wr_period)
				period_register <= AVS_WRITEDATA[7:0];
			// event set wins over a software clear in the same cycle
			if (post_out)
				PERIOD_MATCH_FLAG <= 1'b1;
			else if (wr_flag)
				PERIOD_MATCH_FLAG <=
					AVS_WRITEDATA[`PMT_FLAG_BIT];
		end
	end

	// ****************************************
	// bus handshake and read data
	// ****************************************
	always @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h0;
			AVS_RESPONSE <= 2'h0;
			done <= 1'b0;
		end
		else if (access)
		begin
			AVS_WAITREQUEST <= 1'b0;
			done <= 1'b1;
			AVS_RESPONSE <= 2'h0;
			AVS_READDATA <= 32'h0;
			if (AVS_ADDRESS == `PMT_ADDR_CTRL)
				AVS_READDATA[7:0] <= timer_control_reg;
			else if (AVS_ADDRESS == `PMT_ADDR_COUNT)
				AVS_READDATA[7:0] <= count_register;
			else if (AVS_ADDRESS == `PMT_ADDR_PERIOD)
				AVS_READDATA[7:0] <= period_register;
			else
				AVS_READDATA[`PMT_FLAG_BIT] <= PERIOD_MATCH_FLAG;
		end
		else
		begin
			AVS_WAITREQUEST <= 1'b1;
			done <= 1'b0;
		end
	end

endmodule

// ==== verif/pmt_timer_props.sv ====
// checker for the timer core: bus handshake and match outputs
// assumes a bind to every instance of the core
module pmt_timer_props
(
	// clock and reset
	input logic CLK_SYS,
	input logic RST_N,
	// avalon-mm slave
	input logic [1:0] AVS_ADDRESS,
	input logic AVS_READ,
	input logic AVS_WRITE,
	input logic [31:0] AVS_WRITEDATA,
	input logic [3:0] AVS_BYTEENABLE,
	input logic [31:0] AVS_READDATA,
	input logic AVS_WAITREQUEST,
	input logic [1:0] AVS_RESPONSE,
	// timer state
	input logic PERIOD_MATCH_FLAG,
	input logic POSTSCALE_PULSE
);
// ****
// properties
// ****
default clocking cb @(posedge CLK_SYS); endclocking
default disable iff (!RST_N);
sequence s_req;
	(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
endsequence
sequence s_done;
	!AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
endsequence
a_req_answer: assert property (s_req |=> s_done)
	else $error("access not answered in one cycle");
a_resp_okay: assert property (AVS_RESPONSE == 2'h0)
	else $error("response not okay");
a_rd_upper: assert property (!AVS_WAITREQUEST |-> !(|AVS_READDATA[31:8]))
	else $error("read data upper bits set");
a_wait_idle: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
	else $error("answer without request");
a_ctrl_bit7: assert property (s_req ##0 AVS_ADDRESS == 2'h0 |=> !AVS_READDATA[7])
	else $error("control bit 7 reads one");
a_flag_hold: assert property ($fell(PERIOD_MATCH_FLAG) |-> $past(AVS_WRITE && AVS_ADDRESS == 2'h3 && !AVS_WRITEDATA[0]))
	else $error("flag cleared without write");
a_flag_cause: assert property ($rose(PERIOD_MATCH_FLAG) && !$past(AVS_WRITE) |-> POSTSCALE_PULSE)
	else $error("flag set without pulse");
a_pulse_one: assert property (POSTSCALE_PULSE |=> !POSTSCALE_PULSE)
	else $error("pulse longer than one cycle");
endmodule
bind pmt_timer pmt_timer_props chk (.*);

// ==== verif/pmt_timer_tb_top.sv ====
// bench for the timer core: register access and pulse spacing
// assumes the core answers a request one cycle after taking it
module pmt_timer_tb_top;
timeunit 1ns;
timeprecision 1ns;
logic CLK_SYS = 1'h0, RST_N = 1'h0, AVS_READ = 1'h0, AVS_WRITE = 1'h0;
logic [1:0] AVS_ADDRESS = 2'h0;
logic [31:0] AVS_WRITEDATA = 32'h0, q;
logic [3:0] AVS_BYTEENABLE = 4'hf;
wire [31:0] AVS_READDATA;
wire [1:0] AVS_RESPONSE;
wire AVS_WAITREQUEST, PERIOD_MATCH_FLAG, POSTSCALE_PULSE;
int failures = 0, compares = 0;
pmt_timer dut (.*);
always #20 CLK_SYS = ~CLK_SYS;
task test_done;
	if (failures == 0 && compares > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
	compares++;
	if (g !== e)
	begin
		failures++;
		$display("Error %0t got %h exp %h", $time, g, e);
	end
endtask
// called just after a rising edge; leaves one idle cycle behind
task acc(input logic w, input logic [1:0] a, input logic [7:0] d);
	AVS_ADDRESS <= a;
	AVS_WRITEDATA <= {24'h0, d};
	AVS_WRITE <= w;
	AVS_READ <= !w;
	@(posedge CLK_SYS);
	while (AVS_WAITREQUEST !== 1'b0)
		@(posedge CLK_SYS);
	q = AVS_READDATA;
	AVS_WRITE <= 1'h0;
	AVS_READ <= 1'h0;
	@(posedge CLK_SYS);
endtask
task t_reset;
	for (int a = 0; a < 4; a++)
	begin
		acc(1'h0, a[1:0], 8'h0);
		chk(q, a == 2 ? 32'hff : 32'h0);
	end
endtask
task t_rw;
	logic [7:0] v;
	for (int i = 0; i < 3; i++)
	begin
		v = 8'h5a << i;
		acc(1'h1, 2'h2, v);
		acc(1'h1, 2'h1, ~v);
		acc(1'h0, 2'h2, 8'h0);
		chk(q, {24'h0, v});
		acc(1'h0, 2'h1, 8'h0);
		chk(q, {24'h0, ~v});
	end
	acc(1'h1, 2'h0, 8'hf8);
	acc(1'h0, 2'h0, 8'h0);
	chk(q, 32'h78);
endtask
// pulse spacing is 4 * prescale * (period + 1) * (postscale + 1)
task t_rate(input logic [1:0] pre, input logic [3:0] post);
	int n;
	acc(1'h1, 2'h2, 8'h2);
	acc(1'h1, 2'h0, {1'h0, post, 1'h1, pre});
	n = 0;
	while (POSTSCALE_PULSE !== 1'b1)
		@(posedge CLK_SYS);
	do
	begin
		@(posedge CLK_SYS);
		n++;
	end
	while (POSTSCALE_PULSE !== 1'b1);
	chk(n, 12 * (pre[1] ? 16 : pre[0] ? 4 : 1) * (post + 1));
endtask
task t_stop;
	logic [31:0] c;
	acc(1'h1, 2'h0, 8'h00);
	acc(1'h0, 2'h1, 8'h0);
	c = q;
	repeat (40) @(posedge CLK_SYS);
	acc(1'h1, 2'h0, 8'h78);
	acc(1'h0, 2'h1, 8'h0);
	chk(q, c);
	acc(1'h1, 2'h3, 8'h0);
	acc(1'h0, 2'h3, 8'h0);
	chk(q, 32'h0);
	AVS_BYTEENABLE <= 4'he;
	acc(1'h1, 2'h2, 8'h11);
	AVS_BYTEENABLE <= 4'hf;
	acc(1'h0, 2'h2, 8'h0);
	chk(q, 32'h2);
endtask
initial
begin
	repeat (6) @(posedge CLK_SYS);
	RST_N <= 1'h1;
	@(posedge CLK_SYS);
	t_reset;
	t_rw;
	for (int i = 0; i < 4; i++)
		t_rate(i[1:0], 4'h0);
	t_rate(2'h0, 4'hf);
	t_rate(2'h1, 4'h7);
	acc(1'h0, 2'h3, 8'h0);
	chk(q, 32'h1);
	t_stop;
	test_done;
end
initial
begin
	#2400000;
	failures++;
	test_done;
end
endmodule
